// >>> inc/flash_seq_pkg.sv
// constants, opcodes and types shared by the flash command sequencer
package flash_seq_pkg;

  // ==========================================================
  // opcodes
  localparam logic [7:0] OP_WRITE_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_CHIP_ERASE      = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROG       = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG       = 8'h32;
  localparam logic [7:0] OP_SECTOR_ERASE    = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE     = 8'hd8;
  localparam logic [7:0] OP_SUSPEND         = 8'hb0;
  localparam logic [7:0] OP_RESUME          = 8'h30;
  localparam logic [7:0] OP_SID_READ        = 8'h88;
  localparam logic [7:0] OP_SID_PROG        = 8'ha5;

  // ==========================================================
  // frame layout
  localparam logic [8:0]  PAGE_BYTES        = 9'h100;
  localparam logic [11:0] ADDR_LEN_MAIN     = 12'h003;
  localparam logic [11:0] ADDR_LEN_SID      = 12'h002;
  localparam logic [3:0]  DUMMY_CLKS_SINGLE = 4'h8;
  localparam logic [3:0]  DUMMY_CLKS_QUAD   = 4'h6;
  localparam logic [10:0] SID_USER_LO       = 11'h008;
  localparam logic [23:0] SECTOR_MASK       = 24'h000fff;
  localparam logic [23:0] BLOCK_MASK        = 24'h00ffff;
  localparam logic [23:0] CHIP_MASK         = 24'hffffff;
  localparam logic [1:0]  ERASE_SECTOR      = 2'h0;
  localparam logic [1:0]  ERASE_BLOCK       = 2'h1;
  localparam logic [1:0]  ERASE_CHIP        = 2'h2;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ               = 50;
  localparam int unsigned PAGE_PROGRAM_TIME_US  = 1000;
  localparam int unsigned ERASE_TIME_US         = 20000;
  localparam int unsigned FULL_ERASE_TIME_US    = 50000;
  localparam int unsigned SECURE_ID_PROG_TIME_US = 1000;
  localparam int unsigned SUSPEND_LATENCY_TIME_US = 10;
  localparam logic [31:0] SUSPEND_LATENCY_CYCLES = 32'(SUSPEND_LATENCY_TIME_US * CLK_MHZ);

  // ==========================================================
  // types
  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_CHECK, ST_WALK, ST_TIME, ST_SUSP_WAIT} state_t;
  typedef enum logic [2:0] {K_NONE, K_PP, K_SE, K_BE, K_CE, K_SID} kind_t;

  function automatic logic in_region(input logic [23:0] a, input logic [23:0] base, input logic [23:0] mask);
    in_region = ((a & ~mask) == (base & ~mask));
  endfunction

endpackage

// >>> sim/flash_program_erase_suspend_tb_top.sv
// bench top: host model drives frames, a queue predicts memory writes
module flash_program_erase_suspend_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, srst, sck, cs_n, prot_hit, prot_any, busy, write_latch, mem_wr, mem_erase;
  logic        erase_suspended_flag, program_suspended_flag, quad_mode = 1'b0, quad_io_config_bit = 1'b0;
  logic        sid_locked = 1'b0;
  logic [3:0]  io_in, io_out, io_oe;
  logic [1:0]  mem_erase_size;
  logic [7:0]  mem_data;
  logic [23:0] prot_addr, mem_addr;
  logic [31:0] exp_q[$];
  int          error_cnt = 0, cmp_count = 0, seed = 4, erase_cnt = 0;
  host_model host_model_i (.sck(sck), .cs_n(cs_n), .io_in(io_in), .sdo(io_out[1]));
  flash_program_erase_suspend #(.PROG_CYCLES(40), .ERASE_CYCLES(40), .FULL_ERASE_CYCLES(60),
    .SID_PROG_CYCLES(20)) flash_program_erase_suspend_i (.*);
  // ==========================================================
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input logic [7:0] b[$], input int tail, input bit q = 1'b0);
    host_model_i.frame(b, tail, q);
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic idle_wait;
    for (int i = 0; busy !== 1'b0; i++) begin
      if (i == 3000) begin
        error_cnt++;
        wrap_up();
      end
      @(negedge ref_clk);
    end
  endtask
  // data bytes are random, each page written once; the last byte per slot wins
  task automatic prog(input logic [23:0] a, input int n, input logic ok, input logic [7:0] opc = 8'h02);
    logic [7:0] d;
    logic [7:0] pg [256];
    logic [7:0] fr[$];
    fr = '{opc, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      fr.push_back(d);
      pg[8'(a[7:0] + i)] = d;
    end
    for (int k = 0; ok && k < n && k < 256; k++)
      exp_q.push_back({a[23:8], 8'(a[7:0] + k), pg[8'(a[7:0] + k)]});
    send(fr, (opc == 8'h32) ? 1 : 3, opc == 8'h32);
    idle_wait();
  endtask
  always @(negedge ref_clk) begin
    if (mem_wr === 1'b1)
      check({mem_addr, mem_data}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hffffffff);
    if (mem_erase === 1'b1)
      erase_cnt++;
  end
  initial begin
    srst = 1'b1;
    prot_hit = 1'b0;
    prot_any = 1'b0;
    repeat (3) host_model_i.clk_bit(1'b0);  // link reset needs sck edges
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    repeat (2) host_model_i.clk_bit(1'b0);  // let the link reset drain before the first frame
    idle_wait();
    prog(24'h0012fe, 5, 1'b0);
    check(write_latch, 1'b0);
    send('{8'h06}, 0);
    check(write_latch, 1'b1);
    prot_hit = 1'b1;
    prog(24'h003400, 3, 1'b0);
    check(prot_addr, 24'h003400);
    prot_hit = 1'b0;
    prog(24'h0012fe, 5, 1'b1);
    check(exp_q.size(), 0);
    send('{8'h06}, 0);
    prot_any = 1'b1;
    send('{8'hc7}, 0);
    check(erase_cnt, 0);
    prot_any = 1'b0;
    send('{8'h20, 8'h00, 8'h50, 8'h00}, 0);
    send('{8'hb0}, 0);
    check(erase_suspended_flag, 1'b1);
    idle_wait();
    send('{8'h06}, 0);
    send('{8'hc7}, 0);
    check(erase_cnt, 1);
    send('{8'h30}, 0);
    check(erase_suspended_flag, 1'b0);
    idle_wait();
    send('{8'hc7}, 0);
    idle_wait();
    check(erase_cnt, 2);
    send('{8'h06}, 0);
    prog(24'h000510, 2, 1'b0, 8'h32);
    quad_io_config_bit = 1'b1;
    prog(24'h000510, 300, 1'b1, 8'h32);
    check(exp_q.size(), 0);
    repeat (25000) @(negedge ref_clk);
    send('{8'h06}, 0);
    exp_q.push_back(32'h0077105a);
    send('{8'h02, 8'h00, 8'h77, 8'h10, 8'h5a}, 0);
    send('{8'hb0}, 0);
    check(program_suspended_flag, 1'b1);
    idle_wait();
    send('{8'h06}, 0);
    send('{8'h20, 8'h00, 8'h77, 8'h00}, 0);
    check(erase_cnt, 2);
    send('{8'h30}, 0);
    check(program_suspended_flag, 1'b0);
    idle_wait();
    check(exp_q.size(), 0);
    send('{8'ha5, 8'h00, 8'h04, 8'h55}, 0);
    send('{8'ha5, 8'h00, 8'h10, 8'h3c, 8'hc3}, 0);
    idle_wait();
    send('{8'h88, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00}, 0);
    check(host_model_i.rx[15:0], 16'h3cc3);
    wrap_up();
  end
endmodule

// >>> sim/host_model.sv
// host model: single-wire and quad-data frames on the serial link, mode 0
module host_model (
  output logic       sck,
  output logic       cs_n,
  output logic [3:0] io_in,
  input  logic       sdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rx = 32'h0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h5;
  end
  // ==========================================================
  // clocking: 12 ns period, lines change while sck is low
  // sdo is taken on the rising edge, half a period after the device launched it
  task automatic nib(input logic [3:0] v);
    io_in = v;
    #6 sck = 1'b1;
    rx = {rx[30:0], sdo};
    #6 sck = 1'b0;
  endtask
  task automatic clk_bit(input logic v);
    nib({~io_in[3:1], v});  // unused lines never hold a level
  endtask
  task automatic frame(input logic [7:0] b[$], input int tail, input bit q = 1'b0);
    cs_n = 1'b0;
    foreach (b[i])
      if (q && i > 0) begin
        nib(b[i][7:4]);
        nib(b[i][3:0]);
      end else begin
        for (int k = 7; k >= 0; k--)
          clk_bit(b[i][k]);
      end
    repeat (tail) clk_bit(1'b1);
    #6 cs_n = 1'b1;
    io_in = ~io_in;  // released line, no stale level
  endtask
endmodule

// >>> src/flash_program_erase_suspend.sv
// command sequencer for program, erase, suspend/resume and security id
// Notes on behaviour
// - whole-array erase sets all ones, unless protected
// - busy held until self-timed operation ends
// - page program starts when chip select rises
// - program into protected area is ignored
// - 1..256 bytes; partial trailing byte discarded
// - beyond 256 bytes keep the last 256
// - page address wraps inside the page
// - quad program needs quad config bit set
// - quad program: serial opcode, two-clock nibble bytes
// - only sector/block erase and page programs suspend
// - one suspended write; further suspend ignored
// - no suspend of full erase; none while suspended
// - resume ignored while a new write runs
// - erase suspend sets erase flag; busy until ready
// - no programming of erase-suspended sectors
// - program suspend sets flag; blocks erase of its sector or block
// - resume continues write from its saved timer, clears suspend flag
// - id read: address, dummy, falling-edge data stream
// - id program: user range only, page wrap
// - write-enable command sets the write latch
module flash_program_erase_suspend #(
  parameter int unsigned PROG_CYCLES       = flash_seq_pkg::PAGE_PROGRAM_TIME_US * flash_seq_pkg::CLK_MHZ,
  parameter int unsigned ERASE_CYCLES      = flash_seq_pkg::ERASE_TIME_US * flash_seq_pkg::CLK_MHZ,
  parameter int unsigned FULL_ERASE_CYCLES = flash_seq_pkg::FULL_ERASE_TIME_US * flash_seq_pkg::CLK_MHZ,
  parameter int unsigned SID_PROG_CYCLES   = flash_seq_pkg::SECURE_ID_PROG_TIME_US * flash_seq_pkg::CLK_MHZ,
  // factory identifier, value arbitrary
  parameter logic [63:0] SID_UNIQUE        = 64'h0123_4567_89ab_cdef
) (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  input  wire logic        quad_mode,
  input  wire logic        quad_io_config_bit,
  input  wire logic        prot_hit,
  input  wire logic        prot_any,
  input  wire logic        sid_locked,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  output logic             busy,
  output logic             write_latch,
  output logic             erase_suspended_flag,
  output logic             program_suspended_flag,
  output logic      [23:0] prot_addr,
  output logic             mem_wr,
  output logic             mem_erase,
  output logic      [1:0]  mem_erase_size,
  output logic      [23:0] mem_addr,
  output logic      [7:0]  mem_data
);

  // ==========================================================
  // link side: frame assembly on sck
  logic        link_rst_s1;
  logic        link_rst;
  logic        qm_s1;
  logic        qm_s2;
  logic        in_frame;
  logic [2:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  op;
  logic [23:0] addr;
  logic [11:0] byte_idx;
  logic [8:0]  data_cnt;
  logic [7:0]  wr_off;
  logic        frame_tog;
  logic [7:0]  page_buf [256];
  logic [3:0]  dummy_cnt;
  logic        rd_go;
  logic        rd_started;
  logic [2:0]  out_cnt;
  logic [7:0]  out_sh;
  logic [10:0] rd_ptr;
  logic        wide;
  logic        byte_done;
  logic [7:0]  new_byte;
  logic [11:0] addr_len;
  logic [3:0]  dummy_len;
  logic [10:0] cur_ptr;
  logic [7:0]  fresh;
  logic [7:0]  sid_mem [2048];

  // srst reaches the link only while sck runs; hold it across a few sck edges
  always_ff @(posedge sck) begin
    link_rst_s1 <= srst;
    link_rst    <= link_rst_s1;
    qm_s1       <= quad_mode;
    qm_s2       <= qm_s1;
  end

  assign wide      = qm_s2 | (in_frame && byte_idx != 12'h0 && op == flash_seq_pkg::OP_QUAD_PROG);
  assign byte_done = wide ? bit_cnt[0] : (bit_cnt == 3'h7);
  assign new_byte  = wide ? {shift[3:0], io_in} : {shift[6:0], io_in[0]};
  assign addr_len  = (op == flash_seq_pkg::OP_SID_PROG || op == flash_seq_pkg::OP_SID_READ) ?
                     flash_seq_pkg::ADDR_LEN_SID : flash_seq_pkg::ADDR_LEN_MAIN;
  assign dummy_len = qm_s2 ? flash_seq_pkg::DUMMY_CLKS_QUAD : flash_seq_pkg::DUMMY_CLKS_SINGLE;

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      in_frame <= 1'b0;
      bit_cnt  <= 3'h0;
      shift    <= 8'h00;
    end else begin
      in_frame <= 1'b1;
      bit_cnt  <= byte_done ? 3'h0 : bit_cnt + 3'h1;
      shift    <= new_byte;
    end
  end

  // frame results stay put after cs_n rises, so the core reads them quasi-statically
  always_ff @(posedge sck) begin
    if (link_rst) begin
      frame_tog <= 1'b0;
      byte_idx  <= 12'h0;
      data_cnt  <= 9'h0;
      wr_off    <= 8'h00;
      op        <= 8'h00;
      addr      <= 24'h0;
    end else if (!in_frame && !cs_n) begin
      // only the first edge of a frame; idle sck edges must not look like a frame
      frame_tog <= ~frame_tog;
      byte_idx  <= 12'h0;
      data_cnt  <= 9'h0;
      wr_off    <= 8'h00;
    end else if (byte_done) begin
      if (byte_idx != 12'hfff) begin
        byte_idx <= byte_idx + 12'h1;
      end
      if (byte_idx == 12'h0) begin
        op <= new_byte;
      end else if (byte_idx == 12'h1) begin
        addr <= {16'h0000, new_byte};
      end else if (byte_idx <= addr_len) begin
        addr <= {addr[15:0], new_byte};
      end else begin
        wr_off <= wr_off + 8'h01;
        if (data_cnt != flash_seq_pkg::PAGE_BYTES) begin
          data_cnt <= data_cnt + 9'h1;
        end
      end
    end
  end

  // older bytes are simply overwritten once the slot index wraps
  always_ff @(posedge sck) begin
    if (in_frame && byte_done && byte_idx > addr_len) begin
      page_buf[8'(addr[7:0] + wr_off)] <= new_byte;
    end
  end

  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      dummy_cnt <= 4'h0;
      rd_go     <= 1'b0;
    end else if (in_frame && op == flash_seq_pkg::OP_SID_READ && byte_idx > addr_len && !rd_go) begin
      dummy_cnt <= dummy_cnt + 4'h1;
      rd_go     <= (dummy_cnt + 4'h1 == dummy_len);
    end
  end

  assign cur_ptr = rd_started ? rd_ptr : addr[10:0];
  // id memory only changes while busy, so the link reads it without a crossing
  assign fresh   = sid_mem[cur_ptr];

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      io_out     <= 4'h0;
      io_oe      <= 4'h0;
      out_cnt    <= 3'h0;
      out_sh     <= 8'h00;
      rd_ptr     <= 11'h000;
      rd_started <= 1'b0;
    end else if (rd_go) begin
      rd_started <= 1'b1;
      if (qm_s2) begin
        io_oe   <= 4'hf;
        out_cnt <= {2'b00, ~out_cnt[0]};
        if (!out_cnt[0]) begin
          io_out <= fresh[7:4];
          out_sh <= fresh;
          rd_ptr <= cur_ptr + 11'h001;
        end else begin
          io_out <= out_sh[3:0];
        end
      end else begin
        io_oe   <= 4'h2;
        out_cnt <= out_cnt + 3'h1;
        if (out_cnt == 3'h0) begin
          io_out <= {2'b00, fresh[7], 1'b0};
          out_sh <= {fresh[6:0], 1'b0};
          rd_ptr <= cur_ptr + 11'h001;
        end else begin
          io_out <= {2'b00, out_sh[7], 1'b0};
          out_sh <= {out_sh[6:0], 1'b0};
        end
      end
    end
  end

  // ==========================================================
  // core side: frame end detection
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tog_seen;
  logic frame_end;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cs_s1    <= 1'b1;
      cs_s2    <= 1'b1;
      cs_s3    <= 1'b1;
      tog_seen <= 1'b0;
    end else begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      if (cs_s2 && !cs_s3) begin
        tog_seen <= frame_tog;
      end
    end
  end

  // a frame without any sck edge leaves frame_tog unchanged and is dropped
  assign frame_end = cs_s2 && !cs_s3 && (frame_tog != tog_seen);

  // ==========================================================
  // core side: sequencer
  flash_seq_pkg::state_t state;
  flash_seq_pkg::kind_t  act;
  flash_seq_pkg::kind_t  susp;
  logic [7:0]  cmd_op;
  logic [23:0] cmd_addr;
  logic [8:0]  cmd_cnt;
  logic [31:0] timer;
  logic [31:0] susp_timer;
  logic [23:0] act_mask;
  logic [23:0] susp_base;
  logic [23:0] susp_mask;
  logic [8:0]  walk_idx;
  logic [10:0] init_ptr;
  logic [7:0]  walk_off;
  logic        check_ok;

  assign walk_off = 8'(cmd_addr[7:0] + walk_idx[7:0]);

  always_comb begin
    check_ok = 1'b0;
    case (cmd_op)
      flash_seq_pkg::OP_CHIP_ERASE:
        check_ok = !prot_any && susp == flash_seq_pkg::K_NONE;
      flash_seq_pkg::OP_PAGE_PROG, flash_seq_pkg::OP_QUAD_PROG:
        check_ok = cmd_cnt != 9'h0 && !prot_hit
                   && !(erase_suspended_flag && flash_seq_pkg::in_region(cmd_addr, susp_base, susp_mask))
                   && (cmd_op != flash_seq_pkg::OP_QUAD_PROG || quad_io_config_bit);
      flash_seq_pkg::OP_SECTOR_ERASE:
        check_ok = !prot_hit && !erase_suspended_flag
                   && !(program_suspended_flag && flash_seq_pkg::in_region(susp_base, cmd_addr,
                        flash_seq_pkg::SECTOR_MASK));
      flash_seq_pkg::OP_BLOCK_ERASE:
        check_ok = !prot_hit && !erase_suspended_flag
                   && !(program_suspended_flag && flash_seq_pkg::in_region(susp_base, cmd_addr,
                        flash_seq_pkg::BLOCK_MASK));
      flash_seq_pkg::OP_SID_PROG:
        check_ok = cmd_cnt != 9'h0 && !sid_locked && cmd_addr[23:11] == 13'h0
                   && cmd_addr[10:0] >= flash_seq_pkg::SID_USER_LO;
      default:
        check_ok = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state                  <= flash_seq_pkg::ST_INIT;
      act                    <= flash_seq_pkg::K_NONE;
      susp                   <= flash_seq_pkg::K_NONE;
      busy                   <= 1'b1;
      write_latch            <= 1'b0;
      erase_suspended_flag   <= 1'b0;
      program_suspended_flag <= 1'b0;
      cmd_op                 <= 8'h00;
      cmd_addr               <= 24'h0;
      cmd_cnt                <= 9'h0;
      timer                  <= 32'h0;
      susp_timer             <= 32'h0;
      act_mask               <= 24'h0;
      susp_base              <= 24'h0;
      susp_mask              <= 24'h0;
      walk_idx               <= 9'h0;
      init_ptr               <= 11'h000;
      prot_addr              <= 24'h0;
      mem_wr                 <= 1'b0;
      mem_erase              <= 1'b0;
      mem_erase_size         <= 2'h0;
      mem_addr               <= 24'h0;
      mem_data               <= 8'h00;
    end else begin
      mem_wr    <= 1'b0;
      mem_erase <= 1'b0;
      case (state)
        flash_seq_pkg::ST_INIT: begin
          init_ptr <= init_ptr + 11'h001;
          if (init_ptr == 11'h7ff) begin
            state <= flash_seq_pkg::ST_IDLE;
            busy  <= 1'b0;
          end
        end
        flash_seq_pkg::ST_IDLE: begin
          if (frame_end) begin
            cmd_op    <= op;
            cmd_addr  <= (op == flash_seq_pkg::OP_SID_PROG) ? {8'h00, addr[15:0]} : addr;
            cmd_cnt   <= data_cnt;
            prot_addr <= addr;
            case (op)
              flash_seq_pkg::OP_WRITE_LATCH_SET: write_latch <= 1'b1;
              flash_seq_pkg::OP_RESUME: begin
                if (susp != flash_seq_pkg::K_NONE) begin
                  act                    <= susp;
                  timer                  <= susp_timer;
                  act_mask               <= susp_mask;
                  susp                   <= flash_seq_pkg::K_NONE;
                  erase_suspended_flag   <= 1'b0;
                  program_suspended_flag <= 1'b0;
                  state                  <= flash_seq_pkg::ST_TIME;
                  busy                   <= 1'b1;
                end
              end
              flash_seq_pkg::OP_CHIP_ERASE, flash_seq_pkg::OP_PAGE_PROG, flash_seq_pkg::OP_QUAD_PROG,
              flash_seq_pkg::OP_SECTOR_ERASE, flash_seq_pkg::OP_BLOCK_ERASE, flash_seq_pkg::OP_SID_PROG: begin
                if (write_latch) begin
                  state <= flash_seq_pkg::ST_CHECK;
                  busy  <= 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
        flash_seq_pkg::ST_CHECK: begin
          walk_idx <= 9'h0;
          mem_addr <= cmd_addr;
          if (!check_ok) begin
            state <= flash_seq_pkg::ST_IDLE;
            busy  <= 1'b0;
          end else begin
            write_latch <= 1'b0;
            case (cmd_op)
              flash_seq_pkg::OP_CHIP_ERASE: begin
                act            <= flash_seq_pkg::K_CE;
                act_mask       <= flash_seq_pkg::CHIP_MASK;
                mem_erase      <= 1'b1;
                mem_erase_size <= flash_seq_pkg::ERASE_CHIP;
                timer          <= 32'(FULL_ERASE_CYCLES);
                state          <= flash_seq_pkg::ST_TIME;
              end
              flash_seq_pkg::OP_SECTOR_ERASE, flash_seq_pkg::OP_BLOCK_ERASE: begin
                act            <= (cmd_op == flash_seq_pkg::OP_SECTOR_ERASE) ? flash_seq_pkg::K_SE : flash_seq_pkg::K_BE;
                act_mask       <= (cmd_op == flash_seq_pkg::OP_SECTOR_ERASE) ? flash_seq_pkg::SECTOR_MASK :
                                  flash_seq_pkg::BLOCK_MASK;
                mem_erase      <= 1'b1;
                mem_erase_size <= (cmd_op == flash_seq_pkg::OP_SECTOR_ERASE) ? flash_seq_pkg::ERASE_SECTOR :
                                  flash_seq_pkg::ERASE_BLOCK;
                timer          <= 32'(ERASE_CYCLES);
                state          <= flash_seq_pkg::ST_TIME;
              end
              default: begin
                act      <= (cmd_op == flash_seq_pkg::OP_SID_PROG) ? flash_seq_pkg::K_SID : flash_seq_pkg::K_PP;
                act_mask <= flash_seq_pkg::SECTOR_MASK;
                state    <= flash_seq_pkg::ST_WALK;
              end
            endcase
          end
        end
        flash_seq_pkg::ST_WALK: begin
          if (act == flash_seq_pkg::K_PP) begin
            mem_wr   <= 1'b1;
            mem_addr <= {cmd_addr[23:8], walk_off};
            mem_data <= page_buf[walk_off];
          end
          walk_idx <= walk_idx + 9'h1;
          if (walk_idx + 9'h1 == cmd_cnt) begin
            timer <= (act == flash_seq_pkg::K_SID) ? 32'(SID_PROG_CYCLES) : 32'(PROG_CYCLES);
            state <= flash_seq_pkg::ST_TIME;
          end
        end
        flash_seq_pkg::ST_TIME: begin
          if (frame_end && op == flash_seq_pkg::OP_SUSPEND && susp == flash_seq_pkg::K_NONE
              && (act == flash_seq_pkg::K_PP || act == flash_seq_pkg::K_SE || act == flash_seq_pkg::K_BE)) begin
            susp                   <= act;
            susp_timer             <= timer;
            susp_base              <= cmd_addr;
            susp_mask              <= act_mask;
            erase_suspended_flag   <= (act != flash_seq_pkg::K_PP);
            program_suspended_flag <= (act == flash_seq_pkg::K_PP);
            act                    <= flash_seq_pkg::K_NONE;
            timer                  <= flash_seq_pkg::SUSPEND_LATENCY_CYCLES;
            state                  <= flash_seq_pkg::ST_SUSP_WAIT;
          end else if (timer <= 32'h1) begin
            act   <= flash_seq_pkg::K_NONE;
            state <= flash_seq_pkg::ST_IDLE;
            busy  <= 1'b0;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        flash_seq_pkg::ST_SUSP_WAIT: begin
          if (timer <= 32'h1) begin
            state <= flash_seq_pkg::ST_IDLE;
            busy  <= 1'b0;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: begin
          state <= flash_seq_pkg::ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // one-time area: bits only ever go from one to zero
  always_ff @(posedge ref_clk) begin
    if (state == flash_seq_pkg::ST_INIT) begin
      sid_mem[init_ptr] <= (init_ptr < flash_seq_pkg::SID_USER_LO) ? SID_UNIQUE[{init_ptr[2:0], 3'b000} +: 8] : 8'hff;
    end else if (state == flash_seq_pkg::ST_WALK && act == flash_seq_pkg::K_SID
                 && {cmd_addr[10:8], walk_off} >= flash_seq_pkg::SID_USER_LO) begin
      sid_mem[{cmd_addr[10:8], walk_off}] <= sid_mem[{cmd_addr[10:8], walk_off}] & page_buf[walk_off];
    end
  end

  // ==========================================================
  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  latch_set_a: assert property (state == flash_seq_pkg::ST_IDLE && frame_end && op == flash_seq_pkg::OP_WRITE_LATCH_SET |=> write_latch) else $error("write latch not set");
  no_latch_a: assert property (state == flash_seq_pkg::ST_IDLE && frame_end && !write_latch && op == flash_seq_pkg::OP_PAGE_PROG |=> !busy) else $error("write ran without latch");
  full_erase_prot_a: assert property (state == flash_seq_pkg::ST_CHECK && cmd_op == flash_seq_pkg::OP_CHIP_ERASE && prot_any |=> !mem_erase && !busy) else $error("protected full erase ran");
  full_erase_susp_a: assert property (state == flash_seq_pkg::ST_CHECK && cmd_op == flash_seq_pkg::OP_CHIP_ERASE && susp != flash_seq_pkg::K_NONE |=> !mem_erase) else $error("full erase while suspended");
  quad_cfg_a: assert property (state == flash_seq_pkg::ST_CHECK && cmd_op == flash_seq_pkg::OP_QUAD_PROG && !quad_io_config_bit |=> !busy) else $error("quad program without config");
  page_wrap_a: assert property (mem_wr |-> mem_addr[23:8] == cmd_addr[23:8] && mem_addr[7:0] == 8'(cmd_addr[7:0] + walk_idx[7:0] - 8'h01)) else $error("program left its page");
  erase_susp_a: assert property (state == flash_seq_pkg::ST_TIME && frame_end && op == flash_seq_pkg::OP_SUSPEND && susp == flash_seq_pkg::K_NONE && act == flash_seq_pkg::K_SE |=> erase_suspended_flag && !program_suspended_flag && busy) else $error("erase suspend flag wrong");
  prog_susp_a: assert property (state == flash_seq_pkg::ST_TIME && frame_end && op == flash_seq_pkg::OP_SUSPEND && susp == flash_seq_pkg::K_NONE && act == flash_seq_pkg::K_PP |=> program_suspended_flag ##1 busy) else $error("program suspend flag wrong");
  one_susp_a: assert property (susp != flash_seq_pkg::K_NONE && frame_end && op == flash_seq_pkg::OP_SUSPEND |=> $stable(susp_timer)) else $error("second suspend taken");
  resume_wait_a: assert property (busy && erase_suspended_flag && frame_end && op == flash_seq_pkg::OP_RESUME |=> erase_suspended_flag) else $error("resume taken while busy");
  resume_clear_a: assert property (state == flash_seq_pkg::ST_IDLE && frame_end && op == flash_seq_pkg::OP_RESUME && susp != flash_seq_pkg::K_NONE |=> !erase_suspended_flag && !program_suspended_flag && busy && timer == $past(susp_timer)) else $error("resume did not restart");
  sid_range_a: assert property (state == flash_seq_pkg::ST_CHECK && cmd_op == flash_seq_pkg::OP_SID_PROG && cmd_addr[10:0] < flash_seq_pkg::SID_USER_LO |=> !busy) else $error("factory id area programmed");
  busy_hold_a: assert property (state == flash_seq_pkg::ST_TIME && timer > 32'h1 |=> busy) else $error("busy dropped early");

endmodule
